/* File: common/np_tx_pkg.sv */
// Package with the layout and constants of the next page transmit register.
package np_tx_pkg;

    // ********************************************************************
    // Register map and field layout
    // ********************************************************************

    // Management register number of the next page transmit register.
    localparam logic [4:0]  NP_TX_REG_ADDR  = 5'h08;

    // Value held after reset in the writable fields.
    localparam logic [15:0] NP_TX_RESET     = 16'h0000;

    // Value that a reserved bit always reads back as.
    localparam logic        RESERVED_VALUE  = 1'h0;

    // Width of the message or unformatted code field.
    localparam int          CODE_WIDTH      = 11;

    // Bit of the base link code word whose inverse seeds the toggle.
    localparam int          BASE_TOGGLE_BIT = 11;

    // One next page code word, laid out exactly as the register.
    typedef struct packed {
        logic                  more_pages_flag;    // Bit 15: more pages.
        logic                  reserved;           // Bit 14: reserved.
        logic                  page_format_select; // Bit 13: message page.
        logic                  comply_ack_flag;    // Bit 12: can comply.
        logic                  toggle;             // Bit 11: toggle.
        logic [CODE_WIDTH-1:0] code;               // Bits 10:0: code field.
    } np_word_t;

    // Phase of the next page exchange.
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_NEXT,
        PH_DONE
    } np_phase_t;

    // Whole state of the block, registered as one unit.
    typedef struct packed {
        np_phase_t             phase;       // Exchange phase.
        logic                  more_pages;  // Stored more pages flag.
        logic                  page_format; // Stored page format select.
        logic                  comply_ack;  // Stored compliance flag.
        logic [CODE_WIDTH-1:0] code;        // Stored code field.
        logic                  prev_toggle; // Toggle of the last sent word.
        np_word_t              rdata;       // Read back image.
        logic                  page_valid;  // Word presented this cycle.
        np_word_t              page_word;   // Outgoing next page word.
        logic                  np_active;   // Next page exchange running.
    } np_state_t;

endpackage

/* File: rtl/np_tx_reg.sv */
// Next page transmit register and outgoing next page word generation.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Send next pages only when partner supports them.
// - Outgoing more pages bit follows register flag.
// - Reserved bit always reads back zero.
// - Page format select: zero unformatted, one message.
// - Compliance flag: zero cannot comply, one can.
// - Toggle field reflects previous link code word.
// - Code field carried unchanged into outgoing page.
// - Toggle inverts each page, seeded by base bit.
// - Eleven bit code field, meaning chosen by format.
module np_tx_reg (
    input  wire logic        clk_i,          // 20 MHz core clock.
    input  wire logic        resetn_i,       // Asynchronous reset, low.
    input  wire logic        mgmt_wr_i,      // Management write strobe.
    input  wire logic [4:0]  mgmt_addr_i,    // Management register number.
    input  wire logic [15:0] mgmt_wdata_i,   // Management write data.
    input  wire logic        base_sent_i,    // Base link code word sent.
    input  wire logic [15:0] base_word_i,    // Base link code word sent.
    input  wire logic        partner_np_i,   // Partner supports next pages.
    input  wire logic        page_req_i,     // Next page opportunity.
    output logic      [15:0] mgmt_rdata_o,   // Register read back.
    output logic             page_valid_o,   // Outgoing word valid pulse.
    output logic      [15:0] page_word_o,    // Outgoing next page word.
    output logic             np_active_o     // Next page exchange running.
);

    // ********************************************************************
    // State and helper signals
    // ********************************************************************

    np_tx_pkg::np_state_t state_r;    // Registered block state.
    np_tx_pkg::np_state_t state_nxt;  // Next value of the block state.
    np_tx_pkg::np_word_t  wr_word;    // Write data viewed as fields.
    np_tx_pkg::np_word_t  tx_word;    // Word built from held fields.
    logic                 reg_wr;     // Write aimed at this register.

    assign wr_word = np_tx_pkg::np_word_t'(mgmt_wdata_i);
    assign reg_wr  = mgmt_wr_i && (mgmt_addr_i == np_tx_pkg::NP_TX_REG_ADDR);

    // The outgoing word copies the held fields; the toggle is the inverse of
    // the previous word so the partner can tell a new page from a repeat.
    always_comb begin
        tx_word                    = '0;
        tx_word.more_pages_flag    = state_r.more_pages;
        tx_word.reserved           = np_tx_pkg::RESERVED_VALUE;
        tx_word.page_format_select = state_r.page_format;
        tx_word.comply_ack_flag    = state_r.comply_ack;
        tx_word.toggle             = ~state_r.prev_toggle;
        tx_word.code               = state_r.code;
    end

    // ********************************************************************
    // Next state
    // ********************************************************************

    // One process works out the whole next state.
    always_comb begin
        state_nxt            = state_r;
        state_nxt.page_valid = 1'h0;
        // A write loads the fields; the reserved bit and the toggle are not
        // stored, so a careless reserved value cannot reach the line.
        if (reg_wr) begin
            state_nxt.more_pages  = wr_word.more_pages_flag;
            state_nxt.page_format = wr_word.page_format_select;
            state_nxt.comply_ack  = wr_word.comply_ack_flag;
            state_nxt.code        = wr_word.code;
        end
        if (base_sent_i) begin
            // The base word's toggle bit becomes the previous toggle.
            state_nxt.prev_toggle = base_word_i[np_tx_pkg::BASE_TOGGLE_BIT];
            // Next pages follow only if both ends ask for them.
            if (state_r.more_pages && partner_np_i) begin
                state_nxt.phase = np_tx_pkg::PH_NEXT;
            end else begin
                state_nxt.phase = np_tx_pkg::PH_DONE;
            end
        end else begin
            case (state_r.phase)
                np_tx_pkg::PH_NEXT: begin
                    // The held word goes out at the opportunity.
                    if (page_req_i) begin
                        state_nxt.page_valid  = 1'h1;
                        state_nxt.page_word   = tx_word;
                        state_nxt.prev_toggle = tx_word.toggle;
                        // A clear flag marks the last page.
                        if (!state_r.more_pages) begin
                            state_nxt.phase = np_tx_pkg::PH_DONE;
                        end
                    end
                end
                np_tx_pkg::PH_IDLE: begin
                    state_nxt.phase = np_tx_pkg::PH_IDLE;
                end
                np_tx_pkg::PH_DONE: begin
                    state_nxt.phase = np_tx_pkg::PH_DONE;
                end
                default: begin
                    state_nxt.phase = np_tx_pkg::PH_IDLE;
                end
            endcase
        end
        state_nxt.np_active = (state_nxt.phase == np_tx_pkg::PH_NEXT);
        // Read back image; the toggle shows the previous word's value.
        state_nxt.rdata.more_pages_flag    = state_nxt.more_pages;
        state_nxt.rdata.reserved           =
            np_tx_pkg::RESERVED_VALUE;
        state_nxt.rdata.page_format_select = state_nxt.page_format;
        state_nxt.rdata.comply_ack_flag    = state_nxt.comply_ack;
        state_nxt.rdata.toggle             = state_nxt.prev_toggle;
        state_nxt.rdata.code               = state_nxt.code;
    end

    // ********************************************************************
    // State register
    // ********************************************************************

    // Reset loads constants only.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r             <= '0;
            state_r.phase       <= np_tx_pkg::PH_IDLE;
            state_r.more_pages  <= np_tx_pkg::NP_TX_RESET[15];
            state_r.page_format <= np_tx_pkg::NP_TX_RESET[13];
            state_r.comply_ack  <= np_tx_pkg::NP_TX_RESET[12];
            state_r.code        <= np_tx_pkg::NP_TX_RESET[10:0];
            state_r.rdata       <= np_tx_pkg::NP_TX_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // All outputs come straight from the state register.
    assign mgmt_rdata_o = state_r.rdata;
    assign page_valid_o = state_r.page_valid;
    assign page_word_o  = state_r.page_word;
    assign np_active_o  = state_r.np_active;

    // ********************************************************************
    // Assertions
    // ********************************************************************

    // All checks run on the core clock and sleep while reset is low, so
    // the image that reset forces is never judged against a rule.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // A page goes out one cycle after an opportunity in the next page phase.
    sequence s_opportunity;
        np_active_o && page_req_i && !base_sent_i;
    endsequence

    // A base word has just gone out; its toggle bit seeds the exchange.
    sequence s_base_seen;
        base_sent_i;
    endsequence

    // The reserved position of the read back image never shows a one.
    a_reserved_reads_zero: assert property (
        mgmt_rdata_o[14] == np_tx_pkg::RESERVED_VALUE)
        else $error("reserved bit read back nonzero");

    // Without partner support the exchange stays shut and sends nothing.
    a_partner_gates_np: assert property (
        base_sent_i && !partner_np_i |=> !np_active_o ##1 !page_valid_o)
        else $error("next page phase without partner support");

    // Every accepted opportunity is answered by a valid pulse.
    a_page_on_request: assert property (
        s_opportunity |=> page_valid_o)
        else $error("opportunity did not send a page");

    // More pages and page format come from the fields held at the request.
    a_page_fields_held: assert property (
        s_opportunity |=> page_word_o[15] == $past(state_r.more_pages)
            && page_word_o[13] == $past(state_r.page_format))
        else $error("flags not copied to outgoing page");

    // Compliance flag and code field travel into the page untouched.
    a_ack_and_code: assert property (
        s_opportunity |=> page_word_o[12] == $past(state_r.comply_ack)
            && page_word_o[10:0] == $past(state_r.code))
        else $error("compliance or code field not copied");

    // The previous toggle is reloaded from the seed bit of every base word.
    a_toggle_seeded: assert property (
        s_base_seen |=> state_r.prev_toggle
            == $past(base_word_i[np_tx_pkg::BASE_TOGGLE_BIT]))
        else $error("toggle seed not taken from base word");

    // Each page carries the inverse of the previous toggle, so the first
    // page inverts the base bit and later pages alternate.
    a_toggle_inverts: assert property (
        s_opportunity |=> page_word_o[11] != $past(state_r.prev_toggle))
        else $error("sent toggle did not invert the previous one");

    // The read back toggle follows the word that has just gone out.
    a_toggle_readback: assert property (
        page_valid_o |-> mgmt_rdata_o[11] == page_word_o[11])
        else $error("toggle read back differs from sent word");

    // A page sent with the more pages flag clear closes the exchange.
    a_last_page_stops: assert property (
        (s_opportunity and !state_r.more_pages) |=> !np_active_o)
        else $error("exchange continued after last page");

    // A write to this register shows its code field one cycle later.
    a_write_loads_code: assert property (
        reg_wr |=> mgmt_rdata_o[10:0] == $past(mgmt_wdata_i[10:0]))
        else $error("code field write not stored");

    // The code field and more pages flag only move on a write, never through the exchange.
    a_hold_stable: assert property (
        !reg_wr |=> $stable(state_r.code) && $stable(state_r.more_pages))
        else $error("held fields changed without a write");

endmodule

`default_nettype wire

/* File: verification/link_partner_model.sv */
// Link partner model that drives the far side of the next page exchange.
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// Link partner model
// ************************************************************
module link_partner_model (
    input  wire logic        clk_i,        // Core clock.
    output logic             base_sent_o,  // Base word sent pulse.
    output logic      [15:0] base_word_o,  // Base link code word.
    output logic             partner_np_o, // Next page support.
    output logic             page_req_o    // Next page opportunity.
);
    // All lines idle at time zero.
    initial begin
        base_sent_o  = 1'h0;
        base_word_o  = 16'h0000;
        partner_np_o = 1'h0;
        page_req_o   = 1'h0;
    end

    // Shows the base word for one cycle, then inverts the word lines,
    // so a design that samples them late picks up a wrong value.
    task automatic send_base(input logic [15:0] word, input logic np);
        @(posedge clk_i);
        base_sent_o  <= 1'h1;
        base_word_o  <= word;
        partner_np_o <= np;
        @(posedge clk_i);
        base_sent_o  <= 1'h0;
        base_word_o  <= ~word;
    endtask

    // Offers one next page opportunity as a single-cycle pulse.
    task automatic offer_page();
        @(posedge clk_i);
        page_req_o <= 1'h1;
        @(posedge clk_i);
        page_req_o <= 1'h0;
    endtask
endmodule
`default_nettype wire

/* File: verification/autoneg_next_page_transmit_tb.sv */
// Self-checking testbench for the next page transmit register.
`timescale 1ns/10ps
`default_nettype none

module autoneg_next_page_transmit_tb;
    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic        clk_i    = 1'h0;     // 20 MHz clock.
    logic        resetn_i = 1'h0;     // Active low reset.
    logic        wr       = 1'h0;     // Management write strobe.
    logic [4:0]  addr     = 5'h00;    // Management register number.
    logic [15:0] wdata    = 16'h0000; // Management write data.
    logic        base_sent, partner_np, page_req, page_valid, np_active;
    logic [15:0] base_word, rdata, page_word;
    int          n_errors = 0;        // Mismatches seen.
    int          n_checks = 0;        // Comparisons made.

    always #25 clk_i = ~clk_i;

    np_tx_reg np_tx_reg_i (.clk_i(clk_i), .resetn_i(resetn_i),
        .mgmt_wr_i(wr), .mgmt_addr_i(addr), .mgmt_wdata_i(wdata),
        .base_sent_i(base_sent), .base_word_i(base_word),
        .partner_np_i(partner_np), .page_req_i(page_req),
        .mgmt_rdata_o(rdata), .page_valid_o(page_valid),
        .page_word_o(page_word), .np_active_o(np_active));

    link_partner_model link_partner_model_i (.clk_i(clk_i),
        .base_sent_o(base_sent), .base_word_o(base_word),
        .partner_np_o(partner_np), .page_req_o(page_req));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    // Compares one value; four-state equality so X never matches.
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One write, then checks the read back image a cycle later.
    task automatic write_reg(input logic [4:0] a, input logic [15:0] d,
                             input logic [15:0] exp);
        @(posedge clk_i);
        wr    <= 1'h1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_i);
        wr    <= 1'h0;
        wdata <= ~d;
        #1;
        check("read back", rdata, exp);
    endtask

    // Takes one page; the valid pulse stands for this cycle only.
    task automatic take_page(input logic v, input logic [15:0] w,
                             input logic act);
        link_partner_model_i.offer_page();
        #1;
        check("page valid", 16'(page_valid), 16'(v));
        if (v)
            check("page word", page_word, w);
        check("np active", 16'(np_active), 16'(act));
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Field mapping, ignored bits and a foreign register number.
    task automatic sc_fields();
        logic [15:0] pat [5] = '{16'h8000, 16'h2000, 16'h1000,
                                 16'h07FF, 16'h0000};
        write_reg(5'h09, 16'hBFFF, 16'h0000);
        write_reg(5'h08, 16'hBFFF, 16'hB7FF);
        foreach (pat[k])
            write_reg(5'h08, pat[k], pat[k]);
    endtask

    // Exchanges with and without partner support, both seed values.
    task automatic sc_exchange();
        write_reg(5'h08, 16'hA123, 16'hA123);
        link_partner_model_i.send_base(16'h0800, 1'h0);
        #1;
        take_page(1'h0, 16'h0000, 1'h0);
        link_partner_model_i.send_base(16'h0000, 1'h1);
        #1;
        check("np active", {15'h0000, np_active}, 16'h0001);
        check("toggle seed", rdata, 16'hA123);
        take_page(1'h1, 16'hA923, 1'h1);
        check("toggle back", rdata, 16'hA923);
        write_reg(5'h08, 16'h3155, 16'h3955);
        take_page(1'h1, 16'h3155, 1'h0);
        take_page(1'h0, 16'h0000, 1'h0);
        write_reg(5'h08, 16'h8001, 16'h8001);
        link_partner_model_i.send_base(16'h0800, 1'h1);
        take_page(1'h1, 16'h8001, 1'h1);
        take_page(1'h1, 16'h8801, 1'h1);
    endtask

    // Reset in mid exchange clears every output; page requests are then
    // ignored until a new base word starts an exchange.
    task automatic sc_reset();
        @(posedge clk_i);
        resetn_i <= 1'h0;
        #1;
        check("reset word", page_word, 16'h0000);
        check("reset active", 16'(np_active), 16'h0000);
        @(posedge clk_i);
        resetn_i <= 1'h1;
        #1;
        check("reset image", rdata, 16'h0000);
        take_page(1'h0, 16'h0000, 1'h0);
    endtask

    // ************************************************************
    // Verdict and run control
    // ************************************************************
    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Reset held four cycles, then idle outputs are checked.
    initial begin
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'h1;
        #1;
        check("reset image", rdata, 16'h0000);
        check("reset valid", 16'(page_valid), 16'h0000);
        check("reset active", 16'(np_active), 16'h0000);
        sc_fields();
        sc_exchange();
        sc_reset();
        results();
    end

    // A hang counts as a mismatch and ends the run.
    initial begin
        repeat (4000) @(posedge clk_i);
        n_errors++;
        results();
    end
endmodule
`default_nettype wire
